// ### rtl/emc_pkg.sv
package emc_pkg;
  localparam int CTR_COUNT = 9;
  localparam int ADDR_W = 8;

  // byte offsets inside the slave register window
  localparam logic [7:0] OFS_GOOD_FRAMES_RECEIVED = 8'hB4;
  localparam logic [7:0] OFS_FCS_ERROR_FRAMES = 8'hCC;
  localparam logic [7:0] OFS_RX_OVERRUN_LOST_FRAMES = 8'hCE;
  localparam logic [7:0] OFS_BROADCAST_TX_OCTETS = 8'hD8;
  localparam logic [7:0] OFS_GOOD_FRAMES_SENT = 8'hDC;
  localparam logic [7:0] OFS_DEFERRED_TX_FRAMES = 8'hE4;
  localparam logic [7:0] OFS_CARRIER_LOSS_EVENTS = 8'hF8;
  localparam logic [7:0] OFS_COLLISION_ABORT_FRAMES = 8'hFC;
  localparam logic [7:0] OFS_EXCESS_DEFERRAL_FRAMES = 8'hFE;

  // counter slots, also the bit positions of the per-counter disable vector
  localparam logic [3:0] IDX_GFR = 4'h0;
  localparam logic [3:0] IDX_FCS = 4'h1;
  localparam logic [3:0] IDX_LOSS = 4'h2;
  localparam logic [3:0] IDX_BTO = 4'h3;
  localparam logic [3:0] IDX_GFS = 4'h4;
  localparam logic [3:0] IDX_DEF = 4'h5;
  localparam logic [3:0] IDX_CARR = 4'h6;
  localparam logic [3:0] IDX_ABRT = 4'h7;
  localparam logic [3:0] IDX_XDEF = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;

  localparam logic [31:0] THRESH_32 = 32'hC000_0000;
  localparam logic [15:0] THRESH_16 = 16'hC000;
  localparam logic [31:0] RESET_32 = 32'h0000_0000;
  localparam logic [15:0] RESET_16 = 16'h0000;
  localparam logic [31:0] ONE_32 = 32'h0000_0001;
  localparam logic [15:0] ONE_16 = 16'h0001;
  localparam logic [31:0] VLAN_TAG_OCTETS = 32'h0000_0004;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
endpackage

// ### rtl/emc_ctr_if.sv
`timescale 1ns/1ps
interface emc_ctr_if #(parameter int W = 32);
  logic inc;
  logic [W-1:0] amount;
  logic load;
  logic [W-1:0] wdata;
  logic [W-1:0] value;
  logic hit;
  modport ctl (output inc, output amount, output load, output wdata, input value, input hit);
  modport ctr (input inc, input amount, input load, input wdata, output value, output hit);
endinterface

// ### rtl/emc_counter.sv
`timescale 1ns/1ps
module emc_counter #(
  parameter int W = 32,
  parameter logic [W-1:0] THRESH = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  emc_ctr_if.ctr port
);
  import emc_pkg::*;

  logic [W-1:0] value_q;
  logic [W-1:0] value_d;
  logic hit_q;
  logic hit_d;

  always_comb begin
    value_d = value_q;
    hit_d = 1'b0;
    if (port.load) begin
      value_d = port.wdata;
    end else if (port.inc) begin
      // plain modulo add: wraps to zero past the top, never saturates
      value_d = W'(value_q + port.amount);
      // crossing test so a multi-octet step cannot jump over the threshold
      hit_d = (value_q < THRESH) && (value_d >= THRESH) && (value_d >= value_q);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  assign port.value = value_q;
  assign port.hit = hit_q;

  load_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    port.load |=> value_q == $past(port.wdata))
    else $error("counter did not take written value");

  step_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
    (port.inc && !port.load) |=> value_q == W'($past(value_q) + $past(port.amount)))
    else $error("counter step differs from requested amount");

  read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!port.inc && !port.load) |=> $stable(value_q))
    else $error("counter changed without event or write");

  wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (port.inc && !port.load && (&value_q) && port.amount == W'(1)) |=> value_q == '0)
    else $error("counter did not wrap to zero");

  hit_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit_q |-> (value_q >= THRESH) && ($past(value_q) < THRESH))
    else $error("threshold hit without crossing");
endmodule // emc_counter

// ### rtl/emc_stat_counters.sv
`timescale 1ns/1ps
// Notes on behaviour
// - broadcast tx octets add data plus padding
// - broadcast octet counts add 4 for a vlan tag the mac inserts
// - 32-bit counters raise flag at threshold
// - 16-bit counters raise flag at threshold
// - count only when globally on, unmasked
// - 16-bit counters wrap, never saturate
// - 32-bit frame counters wrap, never saturate
// - count carrier drops during collision-free transmit
// - ignore carrier until preamble and sfd sent
// - count frames aborted by excess collisions
// - count whole-octet fcs failures, not long/short
// - count filtered frames hit by fifo overrun
// - skip frames dropped with fifo full
// - good rx excludes long, fcs, length, alignment and overrun frames
// - count first-attempt deferrals without collision
// - excessive deferral counts once per frame
// - good tx counts each successful frame
module emc_stat_counters (
  input wire logic clk,
  input wire logic rst_n,
  // register access port, byte offset within the window
  input wire logic [emc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // statistics control
  input wire logic counters_global_on,
  input wire logic [emc_pkg::CTR_COUNT-1:0] per_counter_disable,
  input wire logic flag_clear,
  output logic counter_threshold_flag_q,
  // transmit report, qualified by tx_end
  input wire logic tx_end,
  input wire logic tx_ok,
  input wire logic [47:0] tx_dest_addr,
  input wire logic [15:0] tx_octets,
  input wire logic tx_vlan_inserted,
  input wire logic tx_first_deferred,
  input wire logic tx_coll_seen,
  input wire logic tx_excess_coll,
  input wire logic tx_excess_defer,
  // transmit live status
  input wire logic tx_active,
  input wire logic tx_sfd_done,
  input wire logic tx_collision,
  input wire logic tx_crs,
  // receive report, qualified by rx_end
  input wire logic rx_end,
  input wire logic rx_ok,
  input wire logic rx_fcs_bad,
  input wire logic rx_whole_octets,
  input wire logic rx_too_long,
  input wire logic rx_too_short,
  input wire logic rx_len_err,
  input wire logic rx_align_err,
  input wire logic rx_addr_match,
  input wire logic rx_overrun,
  input wire logic rx_dropped_at_start
);
  import emc_pkg::*;

  function automatic logic [3:0] ctr_index(input logic [ADDR_W-1:0] a);
    logic [3:0] idx;
    idx = IDX_NONE;
    unique case (a)
      OFS_GOOD_FRAMES_RECEIVED: idx = IDX_GFR;
      OFS_FCS_ERROR_FRAMES: idx = IDX_FCS;
      OFS_RX_OVERRUN_LOST_FRAMES: idx = IDX_LOSS;
      OFS_BROADCAST_TX_OCTETS: idx = IDX_BTO;
      OFS_GOOD_FRAMES_SENT: idx = IDX_GFS;
      OFS_DEFERRED_TX_FRAMES: idx = IDX_DEF;
      OFS_CARRIER_LOSS_EVENTS: idx = IDX_CARR;
      OFS_COLLISION_ABORT_FRAMES: idx = IDX_ABRT;
      OFS_EXCESS_DEFERRAL_FRAMES: idx = IDX_XDEF;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  emc_ctr_if #(.W(32)) gfr_if ();
  emc_ctr_if #(.W(16)) fcs_if ();
  emc_ctr_if #(.W(16)) loss_if ();
  emc_ctr_if #(.W(32)) bto_if ();
  emc_ctr_if #(.W(32)) gfs_if ();
  emc_ctr_if #(.W(32)) def_if ();
  emc_ctr_if #(.W(16)) carr_if ();
  emc_ctr_if #(.W(16)) abrt_if ();
  emc_ctr_if #(.W(16)) xdef_if ();

  logic [CTR_COUNT-1:0] event_v;
  logic [CTR_COUNT-1:0] inc_v;
  logic [CTR_COUNT-1:0] hit_v;
  logic [31:0] value_a [CTR_COUNT];
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic tx_crs_q;
  logic carrier_drop;
  logic [31:0] bcast_octets;
  logic tx_is_bcast;

  // carrier history, only consulted once the sfd is out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_crs_q <= 1'b0;
    end else begin
      tx_crs_q <= tx_crs;
    end
  end

  assign carrier_drop = tx_crs_q && !tx_crs && tx_active && tx_sfd_done && !tx_collision;

  assign tx_is_bcast = (tx_dest_addr == BCAST_ADDR);
  // mac reports octets without a tag it inserts itself, so put it back
  assign bcast_octets = 32'({16'h0000, tx_octets}
                            + (tx_vlan_inserted ? VLAN_TAG_OCTETS : RESET_32));

  always_comb begin
    event_v = '0;
    event_v[IDX_GFR] = rx_end && rx_ok && !rx_too_long && !rx_fcs_bad && !rx_len_err
                       && !rx_align_err && !rx_overrun;
    event_v[IDX_FCS] = rx_end && rx_fcs_bad && rx_whole_octets && !rx_too_long
                       && !rx_too_short;
    event_v[IDX_LOSS] = rx_end && rx_addr_match && rx_overrun && !rx_dropped_at_start;
    event_v[IDX_BTO] = tx_end && tx_ok && tx_is_bcast;
    event_v[IDX_GFS] = tx_end && tx_ok;
    event_v[IDX_DEF] = tx_end && tx_first_deferred && !tx_coll_seen;
    event_v[IDX_CARR] = carrier_drop;
    event_v[IDX_ABRT] = tx_end && tx_excess_coll;
    // sampled only at frame end, so one frame can never count twice
    event_v[IDX_XDEF] = tx_end && tx_excess_defer;
  end

  assign inc_v = counters_global_on ? (event_v & ~per_counter_disable) : '0;
  assign wr_idx = reg_wr_en ? ctr_index(reg_addr) : IDX_NONE;
  assign rd_idx = ctr_index(reg_addr);

  // a write to a counter wins over a same-cycle event for that counter
  assign gfr_if.inc = inc_v[IDX_GFR];
  assign gfr_if.amount = ONE_32;
  assign gfr_if.load = (wr_idx == IDX_GFR);
  assign gfr_if.wdata = reg_wdata;
  assign fcs_if.inc = inc_v[IDX_FCS];
  assign fcs_if.amount = ONE_16;
  assign fcs_if.load = (wr_idx == IDX_FCS);
  assign fcs_if.wdata = reg_wdata[15:0];
  assign loss_if.inc = inc_v[IDX_LOSS];
  assign loss_if.amount = ONE_16;
  assign loss_if.load = (wr_idx == IDX_LOSS);
  assign loss_if.wdata = reg_wdata[15:0];
  assign bto_if.inc = inc_v[IDX_BTO];
  assign bto_if.amount = bcast_octets;
  assign bto_if.load = (wr_idx == IDX_BTO);
  assign bto_if.wdata = reg_wdata;
  assign gfs_if.inc = inc_v[IDX_GFS];
  assign gfs_if.amount = ONE_32;
  assign gfs_if.load = (wr_idx == IDX_GFS);
  assign gfs_if.wdata = reg_wdata;
  assign def_if.inc = inc_v[IDX_DEF];
  assign def_if.amount = ONE_32;
  assign def_if.load = (wr_idx == IDX_DEF);
  assign def_if.wdata = reg_wdata;
  assign carr_if.inc = inc_v[IDX_CARR];
  assign carr_if.amount = ONE_16;
  assign carr_if.load = (wr_idx == IDX_CARR);
  assign carr_if.wdata = reg_wdata[15:0];
  assign abrt_if.inc = inc_v[IDX_ABRT];
  assign abrt_if.amount = ONE_16;
  assign abrt_if.load = (wr_idx == IDX_ABRT);
  assign abrt_if.wdata = reg_wdata[15:0];
  assign xdef_if.inc = inc_v[IDX_XDEF];
  assign xdef_if.amount = ONE_16;
  assign xdef_if.load = (wr_idx == IDX_XDEF);
  assign xdef_if.wdata = reg_wdata[15:0];

  emc_counter #(.W(32), .THRESH(THRESH_32)) u_gfr (
    .clk(clk), .rst_n(rst_n), .port(gfr_if.ctr)
  );
  emc_counter #(.W(16), .THRESH(THRESH_16)) u_fcs (
    .clk(clk), .rst_n(rst_n), .port(fcs_if.ctr)
  );
  emc_counter #(.W(16), .THRESH(THRESH_16)) u_loss (
    .clk(clk), .rst_n(rst_n), .port(loss_if.ctr)
  );
  emc_counter #(.W(32), .THRESH(THRESH_32)) u_bto (
    .clk(clk), .rst_n(rst_n), .port(bto_if.ctr)
  );
  emc_counter #(.W(32), .THRESH(THRESH_32)) u_gfs (
    .clk(clk), .rst_n(rst_n), .port(gfs_if.ctr)
  );
  emc_counter #(.W(32), .THRESH(THRESH_32)) u_def (
    .clk(clk), .rst_n(rst_n), .port(def_if.ctr)
  );
  emc_counter #(.W(16), .THRESH(THRESH_16)) u_carr (
    .clk(clk), .rst_n(rst_n), .port(carr_if.ctr)
  );
  emc_counter #(.W(16), .THRESH(THRESH_16)) u_abrt (
    .clk(clk), .rst_n(rst_n), .port(abrt_if.ctr)
  );
  emc_counter #(.W(16), .THRESH(THRESH_16)) u_xdef (
    .clk(clk), .rst_n(rst_n), .port(xdef_if.ctr)
  );

  // narrow counters read in the low half, upper bits zero
  assign value_a[IDX_GFR] = gfr_if.value;
  assign value_a[IDX_FCS] = {16'h0000, fcs_if.value};
  assign value_a[IDX_LOSS] = {16'h0000, loss_if.value};
  assign value_a[IDX_BTO] = bto_if.value;
  assign value_a[IDX_GFS] = gfs_if.value;
  assign value_a[IDX_DEF] = def_if.value;
  assign value_a[IDX_CARR] = {16'h0000, carr_if.value};
  assign value_a[IDX_ABRT] = {16'h0000, abrt_if.value};
  assign value_a[IDX_XDEF] = {16'h0000, xdef_if.value};

  assign hit_v = {xdef_if.hit, abrt_if.hit, carr_if.hit, def_if.hit, gfs_if.hit,
                  bto_if.hit, loss_if.hit, fcs_if.hit, gfr_if.hit};

  // reads never disturb a counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= RESET_32;
    end else if (reg_rd_en) begin
      reg_rdata_q <= (rd_idx == IDX_NONE) ? RESET_32 : value_a[rd_idx];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
    end
  end

  // set beats clear so a hit in the clearing cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_threshold_flag_q <= 1'b0;
    end else if (|hit_v) begin
      counter_threshold_flag_q <= 1'b1;
    end else if (flag_clear) begin
      counter_threshold_flag_q <= 1'b0;
    end
  end

  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|hit_v) |=> counter_threshold_flag_q)
    else $error("threshold hit did not set flag");

  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (counter_threshold_flag_q && !flag_clear) |=> counter_threshold_flag_q)
    else $error("flag dropped without clear");

  gate_global_a: assert property (@(posedge clk) disable iff (!rst_n)
    !counters_global_on |-> (inc_v == '0))
    else $error("counter stepped while globally off");

  gate_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (event_v[IDX_GFS] && counters_global_on && !per_counter_disable[IDX_GFS]) |-> gfs_if.inc)
    else $error("enabled counter missed event");

  carrier_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(tx_crs) && tx_active && tx_sfd_done && !tx_collision && counters_global_on
     && !per_counter_disable[IDX_CARR] && !carr_if.load)
    |=> carr_if.value == 16'($past(carr_if.value) + ONE_16))
    else $error("carrier drop not counted");

  carrier_pre_sfd_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tx_sfd_done |-> !carr_if.inc)
    else $error("carrier counted before sfd");

  lost_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_dropped_at_start |-> !loss_if.inc)
    else $error("dropped frame counted as loss");

  read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd_en && ctr_index(reg_addr) == IDX_GFS && !gfs_if.inc && !gfs_if.load)
    |=> reg_rvalid_q && reg_rdata_q == gfs_if.value)
    else $error("read returned wrong counter value");

  abort_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_end && tx_excess_coll && counters_global_on && !per_counter_disable[IDX_ABRT])
    |-> abrt_if.inc)
    else $error("aborted frame not counted");

  fcs_filter_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_end && (rx_too_long || rx_too_short || !rx_whole_octets)) |-> !fcs_if.inc)
    else $error("fcs count took a bad-length frame");

  loss_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_end && rx_addr_match && rx_overrun && !rx_dropped_at_start && counters_global_on
     && !per_counter_disable[IDX_LOSS]) |-> loss_if.inc)
    else $error("visible overrun not counted");

  good_rx_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_end && (rx_too_long || rx_fcs_bad || rx_len_err || rx_align_err || rx_overrun))
    |-> !gfr_if.inc)
    else $error("errored frame counted as good");

  defer_coll_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_end && tx_coll_seen) |-> !def_if.inc)
    else $error("collided frame counted as deferred");

  xdef_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
    xdef_if.inc |-> tx_end)
    else $error("excess deferral counted outside frame end");

  bcast_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    bto_if.inc |-> (tx_end && tx_ok && tx_dest_addr == BCAST_ADDR))
    else $error("non-broadcast octets counted");
endmodule // emc_stat_counters

// ### verif/emc_mac_model.sv
`timescale 1ns/1ps
module emc_mac_model (
  input wire logic clk,
  output logic tx_end,
  output logic [5:0] tx_f,
  output logic [47:0] tx_dest_addr,
  output logic [15:0] tx_octets,
  output logic [3:0] tx_live,
  output logic rx_end,
  output logic [9:0] rx_f
);
  // between reports the qualified fields show inverted junk, so an unqualified use shows up
  initial begin
    tx_end = 1'b0;
    tx_f = 6'h3F;
    tx_dest_addr = 48'h0;
    tx_octets = 16'hFFFF;
    tx_live = 4'h0;
    rx_end = 1'b0;
    rx_f = 10'h3FF;
  end
  // tx_f = {ok, vlan inserted, first deferred, collision seen, excess coll, excess defer}
  task automatic tx_frame(input logic [5:0] f, input logic [47:0] da, input logic [15:0] oct);
    @(negedge clk);
    tx_end = 1'b1;
    tx_f = f;
    tx_dest_addr = da;
    tx_octets = oct;
    @(negedge clk);
    tx_end = 1'b0;
    tx_f = ~f;
    tx_dest_addr = ~da;
    tx_octets = ~oct;
  endtask
  // rx_f = {ok, fcs, whole, long, short, len, align, match, overrun, dropped}
  task automatic rx_frame(input logic [9:0] f);
    @(negedge clk);
    rx_end = 1'b1;
    rx_f = f;
    @(negedge clk);
    rx_end = 1'b0;
    rx_f = ~f;
  endtask
  // tx_live = {active, sfd done, collision, crs}; one carrier drop per call
  task automatic carrier_drop(input logic sfd);
    @(negedge clk);
    tx_live = {1'b1, sfd, 1'b0, 1'b1};
    @(negedge clk);
    tx_live[0] = 1'b0;
    @(negedge clk);
    tx_live = 4'h0;
  endtask
endmodule // emc_mac_model

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
  import emc_pkg::*;
  logic clk, rst_n, reg_wr_en, reg_rd_en, counters_global_on, flag_clear;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, exp_w;
  logic reg_rvalid_q, counter_threshold_flag_q;
  logic [CTR_COUNT-1:0] per_counter_disable;
  logic [CTR_COUNT-1:0] is16 = 9'h1C6;
  wire tx_end, tx_ok, tx_vlan_inserted, tx_first_deferred, tx_coll_seen, tx_excess_coll;
  wire tx_excess_defer, tx_active, tx_sfd_done, tx_collision, tx_crs, rx_end, rx_ok;
  wire rx_fcs_bad, rx_whole_octets, rx_too_long, rx_too_short, rx_len_err, rx_align_err;
  wire rx_addr_match, rx_overrun, rx_dropped_at_start;
  wire [47:0] tx_dest_addr;
  wire [15:0] tx_octets;
  logic [31:0] m [CTR_COUNT];
  logic [7:0] ofs [CTR_COUNT];
  logic [31:0] expq [$];
  int bad_count, n_compared, cycles;
  integer seed = 32'hf6c8;
  logic [15:0] r;

  emc_stat_counters emc_stat_counters_i (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en,
    .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .counters_global_on, .per_counter_disable,
    .flag_clear, .counter_threshold_flag_q, .tx_end, .tx_ok, .tx_dest_addr, .tx_octets,
    .tx_vlan_inserted, .tx_first_deferred, .tx_coll_seen, .tx_excess_coll, .tx_excess_defer,
    .tx_active, .tx_sfd_done, .tx_collision, .tx_crs, .rx_end, .rx_ok, .rx_fcs_bad,
    .rx_whole_octets, .rx_too_long, .rx_too_short, .rx_len_err, .rx_align_err,
    .rx_addr_match, .rx_overrun, .rx_dropped_at_start);
  emc_mac_model emc_mac_model_i (.clk, .tx_end, .tx_dest_addr, .tx_octets, .rx_end,
    .tx_f({tx_ok, tx_vlan_inserted, tx_first_deferred, tx_coll_seen, tx_excess_coll,
      tx_excess_defer}),
    .tx_live({tx_active, tx_sfd_done, tx_collision, tx_crs}),
    .rx_f({rx_ok, rx_fcs_bad, rx_whole_octets, rx_too_long, rx_too_short, rx_len_err,
      rx_align_err, rx_addr_match, rx_overrun, rx_dropped_at_start}));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  // read results come back in request order, one per rvalid
  always @(negedge clk) begin
    if (reg_rvalid_q === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("Error %0t: read data without request", $time);
      end else begin
        exp_w = expq.pop_front();
        `CHK(reg_rdata_q, exp_w)
      end
    end
  end

  task automatic bump(input logic [3:0] i, input logic [31:0] amt);
    if (counters_global_on && !per_counter_disable[i]) begin
      m[i] = m[i] + amt;
      if (is16[i]) m[i][31:16] = 16'h0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    expq.push_back(e);
    @(negedge clk);
    reg_rd_en = 1'b0;
  endtask
  task automatic check_all();
    for (int i = 0; i < CTR_COUNT; i++) rd(ofs[i], m[i]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    for (int i = 0; i < CTR_COUNT; i++) if (ofs[i] == a) m[i] = is16[i] ? {16'h0, v[15:0]} : v;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic tx(input logic [5:0] f, input logic [47:0] da, input logic [15:0] oct);
    emc_mac_model_i.tx_frame(f, da, oct);
    if (f[5]) bump(IDX_GFS, 32'd1);
    if (f[5] && da == BCAST_ADDR) bump(IDX_BTO, {16'h0, oct} + (f[4] ? 32'd4 : 32'd0));
    if (f[3] && !f[2]) bump(IDX_DEF, 32'd1);
    if (f[1]) bump(IDX_ABRT, 32'd1);
    if (f[0]) bump(IDX_XDEF, 32'd1);
  endtask
  task automatic rx(input logic [9:0] f);
    emc_mac_model_i.rx_frame(f);
    if (f[9] && !f[8] && !f[6] && f[4:3] == 2'h0 && !f[1]) bump(IDX_GFR, 32'h1);
    if (f[8] && f[7] && !f[6] && !f[5]) bump(IDX_FCS, 32'd1);
    if (f[2] && f[1] && !f[0]) bump(IDX_LOSS, 32'd1);
  endtask
  task automatic carr(input logic sfd);
    emc_mac_model_i.carrier_drop(sfd);
    if (sfd) bump(IDX_CARR, 32'd1);
  endtask

  initial begin
    ofs = '{OFS_GOOD_FRAMES_RECEIVED, OFS_FCS_ERROR_FRAMES, OFS_RX_OVERRUN_LOST_FRAMES,
      OFS_BROADCAST_TX_OCTETS, OFS_GOOD_FRAMES_SENT, OFS_DEFERRED_TX_FRAMES,
      OFS_CARRIER_LOSS_EVENTS, OFS_COLLISION_ABORT_FRAMES, OFS_EXCESS_DEFERRAL_FRAMES};
    for (int i = 0; i < CTR_COUNT; i++) m[i] = 32'h0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 32'h0;
    counters_global_on = 1'b1;
    per_counter_disable = '0;
    flag_clear = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check_all();
    check_all();
    wr(8'h01, 32'hFFFF_FFFF);
    rd(8'h01, 32'h0);
    r = 16'($random(seed));
    tx(6'b110000, BCAST_ADDR, 16'd60);
    tx(6'b100000, BCAST_ADDR, r);
    tx(6'b110000, 48'h0000_1234_5678, 16'd99);
    tx(6'b101000, 48'h1, 16'd64);
    tx(6'b101100, 48'h1, 16'd64);
    tx(6'b000010, 48'h1, 16'd64);
    tx(6'b100001, 48'h1, 16'd64);
    carr(1'b1);
    carr(1'b0);
    rx(10'b1010000000);
    rx(10'b0110000000);
    rx(10'b0111000000);
    rx(10'b0100000000);
    rx(10'b1000000110);
    rx(10'b0000000111);
    check_all();
    counters_global_on = 1'b0;
    tx(6'b110000, BCAST_ADDR, 16'd70);
    counters_global_on = 1'b1;
    per_counter_disable = 9'h010;
    tx(6'b110000, BCAST_ADDR, 16'd70);
    per_counter_disable = '0;
    wr(OFS_COLLISION_ABORT_FRAMES, 32'h0000_FFFF);
    tx(6'b000010, 48'h1, 16'd64);
    wr(OFS_GOOD_FRAMES_SENT, 32'hFFFF_FFFF);
    tx(6'b100000, 48'h1, 16'd64);
    wr(OFS_DEFERRED_TX_FRAMES, $random(seed) & 32'h7FFF_FFFF);
    check_all();
    `CHK(counter_threshold_flag_q, 1'b0)
    wr(OFS_EXCESS_DEFERRAL_FRAMES, 32'h0000_BFFF);
    tx(6'b100001, 48'h1, 16'd64);
    `CHK(counter_threshold_flag_q, 1'b0)
    @(negedge clk);
    `CHK(counter_threshold_flag_q, 1'b1)
    tx(6'b100001, 48'h1, 16'd64);
    repeat (4) @(negedge clk);
    `CHK(counter_threshold_flag_q, 1'b1)
    flag_clear = 1'b1;
    @(negedge clk);
    flag_clear = 1'b0;
    `CHK(counter_threshold_flag_q, 1'b0)
    wr(OFS_GOOD_FRAMES_RECEIVED, 32'hBFFF_FFFF);
    rx(10'b1010000000);
    @(negedge clk);
    `CHK(counter_threshold_flag_q, 1'b1)
    check_all();
    repeat (3) @(negedge clk);
    `CHK(expq.size(), 0)
    end_sim();
  end
endmodule // tb
